// ==== src/hbbs_pkg.sv ====
package hbbs_pkg;
  localparam int CLK_MHZ = 200;
  localparam int GLITCH_US = 500;
  localparam int GLITCH_CYC = GLITCH_US * CLK_MHZ;
  localparam int STOP_MS = 20;
  localparam int STOP_CYC = STOP_MS * 1000 * CLK_MHZ;
  localparam int SKEW_S = 10;
  localparam longint SKEW_CYC = longint'(SKEW_S) * 1000 * 1000 * CLK_MHZ;
  localparam int BLINK_MS = 1000;
  localparam int BLINK_CYC = BLINK_MS * 1000 * CLK_MHZ;
  localparam int HBB_BIT = 10;
  localparam logic [7:0] CMD_SERVO_ON_CMD = 8'h31;
  localparam logic [7:0] CMD_SERVO_OFF_CMD = 8'h32;
  localparam logic [7:0] CMD_STATUS_MON = 8'h30;
  localparam logic [7:0] CMD_INTERP = 8'h34;
  localparam logic [7:0] CMD_POSN = 8'h35;
  localparam logic [7:0] CMD_FEED = 8'h36;
  localparam logic [7:0] CMD_LATCH = 8'h38;
  localparam logic [7:0] CMD_EXPOS = 8'h39;
  localparam logic [7:0] CMD_HOMING = 8'h3A;
  localparam logic [7:0] CMD_CLR_WARN = 8'h06;
  typedef enum logic [2:0] {
    DSP_RUN = 3'b000,
    DSP_POWER_OFF = 3'b001,
    DSP_POLARITY = 3'b010,
    DSP_BOTH_INH = 3'b011,
    DSP_FWD_INH = 3'b100,
    DSP_REV_INH = 3'b101,
    DSP_HBB = 3'b110
  } hbbs_disp_type;
  typedef enum logic [1:0] {
    ST_BLOCKED = 2'b00,
    ST_WAIT_OFF = 2'b01,
    ST_READY = 2'b10,
    ST_RUN = 2'b11
  } hbbs_state_type;
  localparam int APB_CTRL = 'h00;
  localparam int APB_STAT = 'h04;
  localparam int APB_IRQ = 'h08;
  localparam int APB_MASK = 'h0C;
endpackage

// ==== src/hbbs_link_if.sv ====
interface hbbs_link_if;
  logic cmd_valid;
  logic [7:0] cmd_code;
  logic [15:0] io_monitor;
  logic drive_on_flag;
  logic cmd_warning;
  logic input_timing_alarm;
  modport dev (input cmd_valid, input cmd_code, output io_monitor, output drive_on_flag,
    output cmd_warning, output input_timing_alarm);
  modport host (output cmd_valid, output cmd_code, input io_monitor, input drive_on_flag,
    input cmd_warning, input input_timing_alarm);
endinterface

// ==== src/hbbs_device.sv ====
// What this block does
// - Either safety input off enters blocked state
// - Each channel alone gates the run signal
// - Report blocked flag in monitor bit 10
// - Resume only after servo on command
// - Servo on while blocked needs off first; once inputs return, any command but servo on also clears it
// - Blocked status held until servo on
// - Command warning if blocked during action
// - Host stops action commands before blocking
// - Alarm when channels disagree ten seconds
// - Motor power removed within 20 ms
// - Ignore off pulses of 0.5 ms or less
// - Blocking acts in utility function mode
// - Listed utility functions need cancel, re-entry
// - Brake release drops at once on blocking; after servo off it drops once BRAKE_DLY_CYCLES non-run cycles have passed since the last blocking
// - Dynamic brake stops when stop method selects
// - Distinct display code per drive condition
// - Hide no-motor marker during alarm or blink
// - Safety unit drives both channels redundantly
//
// The address map and register access over APB are this design's own decisions.
module hbbs_device
  import hbbs_pkg::*;
#(
  parameter int GLITCH_CYCLES = GLITCH_CYC,
  parameter int STOP_CYCLES = STOP_CYC,
  parameter longint SKEW_CYCLES = SKEW_CYC,
  parameter int BLINK_CYCLES = BLINK_CYC,
  parameter int BRAKE_DLY_CYCLES = 1000
) (
  input wire logic CLK,
  input wire logic RSTN,
  hbbs_link_if.dev LINK,
  input wire logic SAFETY_IN_A,
  input wire logic SAFETY_IN_B,
  input wire logic STOP_METHOD_SETTING,
  input wire logic UTILITY_MODE,
  input wire logic UTILITY_LATCHING,
  input wire logic UTILITY_CANCEL,
  input wire logic POLARITY_DETECT,
  input wire logic FWD_INHIBIT,
  input wire logic REV_INHIBIT,
  input wire logic ALARM_SHOWN,
  input wire logic AUTOTUNE_SHOWN,
  input wire logic UTIL_RESULT_EVT,
  input wire logic NO_MOTOR_TEST,
  output logic RUN_ENABLE_A,
  output logic RUN_ENABLE_B,
  output logic MOTOR_POWER,
  output logic BRAKE_RELEASE_OUT,
  output logic DYN_BRAKE,
  output logic UTILITY_LOCKED,
  output hbbs_disp_type DISP_CODE,
  output logic NO_MOTOR_MARK
);
  import hbbs_pkg::*;

  logic [1:0] sync_a_ff, sync_b_ff;
  logic filt_a_ff, filt_b_ff;
  logic [31:0] cnt_a_ff, cnt_b_ff;
  logic blocked_ff;
  hbbs_state_type state_ff;
  logic prev_block_ff;
  logic [63:0] skew_ff;
  logic [31:0] stop_ff;
  logic [31:0] brk_ff;
  logic [31:0] blink_ff;
  logic warn_ff, alarm_ff, on_ff, lock_ff, dyn_ff, pwr_ff, brake_ff, mark_ff;
  logic ena_ff, enb_ff;
  hbbs_disp_type disp_ff;
  logic any_off, both_on, block_rise, cmd_on, cmd_off, action_busy_ff;

  function automatic logic is_action(input logic [7:0] c);
    return c == CMD_SERVO_ON_CMD || c == CMD_INTERP || c == CMD_POSN || c == CMD_FEED ||
      c == CMD_LATCH || c == CMD_EXPOS || c == CMD_HOMING;
  endfunction

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      sync_a_ff <= 2'h0;
      sync_b_ff <= 2'h0;
    end else begin
      sync_a_ff <= {sync_a_ff[0], SAFETY_IN_A};
      sync_b_ff <= {sync_b_ff[0], SAFETY_IN_B};
    end
  end

  // Off only after it outlasts the glitch window
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      filt_a_ff <= 1'b0;
      filt_b_ff <= 1'b0;
      cnt_a_ff <= 32'h0;
      cnt_b_ff <= 32'h0;
    end else begin
      if (sync_a_ff[1]) begin
        filt_a_ff <= 1'b1;
        cnt_a_ff <= 32'h0;
      end else if (cnt_a_ff >= 32'(GLITCH_CYCLES)) begin
        filt_a_ff <= 1'b0;
      end else begin
        cnt_a_ff <= cnt_a_ff + 32'h1;
      end
      if (sync_b_ff[1]) begin
        filt_b_ff <= 1'b1;
        cnt_b_ff <= 32'h0;
      end else if (cnt_b_ff >= 32'(GLITCH_CYCLES)) begin
        filt_b_ff <= 1'b0;
      end else begin
        cnt_b_ff <= cnt_b_ff + 32'h1;
      end
    end
  end

  assign any_off = !filt_a_ff || !filt_b_ff;
  assign both_on = filt_a_ff && filt_b_ff;
  assign block_rise = any_off && !prev_block_ff;
  assign cmd_on = LINK.cmd_valid && LINK.cmd_code == CMD_SERVO_ON_CMD;
  assign cmd_off = LINK.cmd_valid && LINK.cmd_code == CMD_SERVO_OFF_CMD;

  // Resume sequence; state machine does not depend on utility mode
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      state_ff <= ST_BLOCKED;
      blocked_ff <= 1'b1;
      prev_block_ff <= 1'b1;
    end else begin
      prev_block_ff <= any_off;
      if (any_off) begin
        blocked_ff <= 1'b1;
        if (cmd_on) begin
          state_ff <= ST_WAIT_OFF;
        end else if (cmd_off) begin
          state_ff <= ST_READY;
        end
      end else begin
        case (state_ff)
          ST_BLOCKED: if (cmd_on) begin
            state_ff <= ST_RUN;
            blocked_ff <= 1'b0;
          end else if (cmd_off) begin
            state_ff <= ST_READY;
          end
          ST_WAIT_OFF: if (LINK.cmd_valid && !cmd_on) begin
            state_ff <= ST_READY;
          end
          ST_READY: if (cmd_on) begin
            state_ff <= ST_RUN;
            blocked_ff <= 1'b0;
          end
          ST_RUN: if (cmd_off) begin
            state_ff <= ST_READY;
          end
          default: state_ff <= ST_BLOCKED;
        endcase
      end
      if (block_rise && state_ff != ST_WAIT_OFF) begin
        state_ff <= ST_BLOCKED;
      end
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      action_busy_ff <= 1'b0;
      warn_ff <= 1'b0;
    end else begin
      if (LINK.cmd_valid) begin
        action_busy_ff <= is_action(LINK.cmd_code);
      end
      if (block_rise && action_busy_ff) begin
        warn_ff <= 1'b1;
      end else if (LINK.cmd_valid && LINK.cmd_code == CMD_CLR_WARN) begin
        warn_ff <= 1'b0;
      end
    end
  end

  // Channel disagreement timer
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      skew_ff <= 64'h0;
      alarm_ff <= 1'b0;
    end else if (filt_a_ff != filt_b_ff) begin
      if (skew_ff >= 64'(SKEW_CYCLES)) begin
        alarm_ff <= 1'b1;
      end else begin
        skew_ff <= skew_ff + 64'h1;
      end
    end else begin
      skew_ff <= 64'h0;
      if (LINK.cmd_valid && LINK.cmd_code == CMD_CLR_WARN) begin
        alarm_ff <= 1'b0;
      end
    end
  end

  // Power and brakes
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      ena_ff <= 1'b0;
      enb_ff <= 1'b0;
      pwr_ff <= 1'b0;
      stop_ff <= 32'h0;
      brake_ff <= 1'b0;
      brk_ff <= 32'h0;
      dyn_ff <= 1'b0;
    end else begin
      ena_ff <= filt_a_ff && !blocked_ff;
      enb_ff <= filt_b_ff && !blocked_ff;
      if (any_off) begin
        pwr_ff <= 1'b0;
        stop_ff <= 32'h0;
        brake_ff <= 1'b0;
        brk_ff <= 32'h0;
      end else if (state_ff == ST_RUN) begin
        pwr_ff <= 1'b1;
        brake_ff <= 1'b1;
      end else begin
        pwr_ff <= 1'b0;
        if (brk_ff >= 32'(BRAKE_DLY_CYCLES)) begin
          brake_ff <= 1'b0;
        end else begin
          brk_ff <= brk_ff + 32'h1;
        end
      end
      if (state_ff == ST_RUN && !any_off) begin
        stop_ff <= 32'h0;
      end else if (stop_ff < 32'(STOP_CYCLES)) begin
        stop_ff <= stop_ff + 32'h1;
      end
      dyn_ff <= any_off && STOP_METHOD_SETTING && stop_ff < 32'(STOP_CYCLES);
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      lock_ff <= 1'b0;
    end else if (block_rise && UTILITY_MODE && UTILITY_LATCHING) begin
      lock_ff <= 1'b1;
    end else if (UTILITY_CANCEL) begin
      lock_ff <= 1'b0;
    end
  end

  // Display and no-motor marker
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      disp_ff <= DSP_HBB;
      blink_ff <= 32'h0;
      mark_ff <= 1'b0;
    end else begin
      if (blocked_ff) begin
        disp_ff <= DSP_HBB;
      end else if (POLARITY_DETECT) begin
        disp_ff <= DSP_POLARITY;
      end else if (FWD_INHIBIT && REV_INHIBIT) begin
        disp_ff <= DSP_BOTH_INH;
      end else if (FWD_INHIBIT) begin
        disp_ff <= DSP_FWD_INH;
      end else if (REV_INHIBIT) begin
        disp_ff <= DSP_REV_INH;
      end else if (pwr_ff) begin
        disp_ff <= DSP_RUN;
      end else begin
        disp_ff <= DSP_POWER_OFF;
      end
      if (UTIL_RESULT_EVT) begin
        blink_ff <= 32'(BLINK_CYCLES);
      end else if (blink_ff != 32'h0) begin
        blink_ff <= blink_ff - 32'h1;
      end
      mark_ff <= NO_MOTOR_TEST && !ALARM_SHOWN && !AUTOTUNE_SHOWN &&
        blink_ff == 32'h0 && !UTIL_RESULT_EVT;
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      on_ff <= 1'b0;
    end else begin
      on_ff <= state_ff == ST_RUN && !any_off;
    end
  end

  assign LINK.io_monitor = {5'h00, blocked_ff, 10'h000};
  assign LINK.drive_on_flag = on_ff;
  assign LINK.cmd_warning = warn_ff;
  assign LINK.input_timing_alarm = alarm_ff;
  assign RUN_ENABLE_A = ena_ff;
  assign RUN_ENABLE_B = enb_ff;
  assign MOTOR_POWER = pwr_ff;
  assign BRAKE_RELEASE_OUT = brake_ff;
  assign DYN_BRAKE = dyn_ff;
  assign UTILITY_LOCKED = lock_ff;
  assign DISP_CODE = disp_ff;
  assign NO_MOTOR_MARK = mark_ff;
endmodule // hbbs_device

// ==== src/hbbs_host.sv ====
// Host: APB registers issue commands; status and events read back
module hbbs_host
  import hbbs_pkg::*;
(
  input wire logic CLK,
  input wire logic RSTN,
  hbbs_link_if.host LINK,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [31:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic IRQ
);
  import hbbs_pkg::*;

  logic cv_ff;
  logic [7:0] cc_ff;
  logic [2:0] irq_ff, mask_ff, prev_ff;
  logic [31:0] rd_ff;
  logic rdy_ff, err_ff, int_ff;
  logic acc, wr, hit;
  logic [2:0] ev;

  assign acc = PSEL && PENABLE && !rdy_ff;
  // Writes land on the edge that sees PREADY high
  assign wr = PSEL && PENABLE && rdy_ff && PWRITE;
  assign hit = PADDR == APB_CTRL || PADDR == APB_STAT || PADDR == APB_IRQ || PADDR == APB_MASK;
  assign ev = {LINK.input_timing_alarm, LINK.cmd_warning, LINK.io_monitor[HBB_BIT]} & ~prev_ff;

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      rdy_ff <= 1'b0;
      err_ff <= 1'b0;
      rd_ff <= 32'h0;
    end else begin
      rdy_ff <= acc;
      err_ff <= acc && !hit;
      if (acc && !PWRITE) begin
        case (PADDR)
          APB_STAT: rd_ff <= {28'h0, LINK.input_timing_alarm, LINK.cmd_warning,
            LINK.drive_on_flag, LINK.io_monitor[HBB_BIT]};
          APB_IRQ: rd_ff <= {29'h0, irq_ff};
          APB_MASK: rd_ff <= {29'h0, mask_ff};
          default: rd_ff <= 32'h0;
        endcase
      end
    end
  end

  // Write one byte code to CTRL sends one command pulse
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      cv_ff <= 1'b0;
      cc_ff <= 8'h00;
    end else begin
      cv_ff <= wr && PADDR == APB_CTRL;
      if (wr && PADDR == APB_CTRL) begin
        cc_ff <= PWDATA[7:0];
      end
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      irq_ff <= 3'h0;
      mask_ff <= 3'h0;
      prev_ff <= 3'h0;
      int_ff <= 1'b0;
    end else begin
      prev_ff <= {LINK.input_timing_alarm, LINK.cmd_warning, LINK.io_monitor[HBB_BIT]};
      if (wr && PADDR == APB_IRQ) begin
        irq_ff <= (irq_ff & ~PWDATA[2:0]) | ev;
      end else begin
        irq_ff <= irq_ff | ev;
      end
      if (wr && PADDR == APB_MASK) begin
        mask_ff <= PWDATA[2:0];
      end
      int_ff <= |(irq_ff & mask_ff);
    end
  end

  assign LINK.cmd_valid = cv_ff;
  assign LINK.cmd_code = cc_ff;
  assign PRDATA = rd_ff;
  assign PREADY = rdy_ff;
  assign PSLVERR = err_ff;
  assign IRQ = int_ff;
endmodule // hbbs_host

// ==== tb/hbbs_monitor.sv ====
module hbbs_monitor (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] io_monitor,
  input wire logic drive_on_flag,
  input wire logic cmd_warning,
  input wire logic input_timing_alarm
);
  import hbbs_pkg::*;
  wire on_cmd = cmd_valid && (cmd_code == CMD_SERVO_ON_CMD);
  wire clr_cmd = cmd_valid && (cmd_code == CMD_CLR_WARN);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);
  sequence s_unblock;
    $fell(io_monitor[10]);
  endsequence
  sequence s_held_block;
    io_monitor[10] [*3];
  endsequence
  chk_mon_spare_zero: assert property ((io_monitor & 16'hFBFF) == 16'h0000)
    else $error("monitor spare bits set");
  chk_unblock_cause: assert property (s_unblock |-> $past(on_cmd))
    else $error("unblocked without servo on");
  chk_unblock_runs: assert property (s_unblock |=> drive_on_flag)
    else $error("no run after unblock");
  chk_blocked_stopped: assert property (s_held_block |-> !drive_on_flag)
    else $error("running while blocked");
  chk_run_rise_clear: assert property ($rose(drive_on_flag) |-> !io_monitor[10])
    else $error("run rose while flagged");
  chk_block_held: assert property (io_monitor[10] && !on_cmd |=> io_monitor[10])
    else $error("block flag dropped");
  chk_warn_held: assert property (cmd_warning && !clr_cmd |=> cmd_warning)
    else $error("warning dropped");
  chk_warn_cause: assert property ($rose(cmd_warning) |-> ##[0:3] io_monitor[10])
    else $error("warning without block");
  chk_alarm_held: assert property (input_timing_alarm && !clr_cmd |=> input_timing_alarm)
    else $error("alarm dropped");
  chk_cmd_one_pulse: assert property (cmd_valid |=> !cmd_valid)
    else $error("command pulse too long");
endmodule // hbbs_monitor

// ==== tb/testbench.sv ====
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import hbbs_pkg::*;
  logic CLK, RSTN, sa, sb, stop_m, u_mode, u_latch, u_cancel, pol, fwd, rev;
  logic alarm_s, tune_s, u_evt, nmt, psel, penable, pwrite, pready, pslverr, irq, e, i0;
  logic run_a, run_b, mpow, brake, dyn, u_lock, nm_mark;
  logic [31:0] paddr, pwdata, prdata, r, t;
  logic [31:0] seed = 32'h2A8A;
  logic [7:0] codes [8] = '{CMD_STATUS_MON, CMD_SERVO_ON_CMD, CMD_INTERP, CMD_POSN, CMD_FEED,
    CMD_LATCH, CMD_EXPOS, CMD_HOMING};
  hbbs_disp_type disp;
  int err_count = 0, num_checks = 0, cyc = 0;
  hbbs_link_if link();
  hbbs_device #(.GLITCH_CYCLES(4), .STOP_CYCLES(100), .SKEW_CYCLES(50), .BLINK_CYCLES(20),
    .BRAKE_DLY_CYCLES(10)) hbbs_device_inst (.CLK(CLK), .RSTN(RSTN), .LINK(link),
    .SAFETY_IN_A(sa), .SAFETY_IN_B(sb), .STOP_METHOD_SETTING(stop_m), .UTILITY_MODE(u_mode),
    .UTILITY_LATCHING(u_latch), .UTILITY_CANCEL(u_cancel), .POLARITY_DETECT(pol),
    .FWD_INHIBIT(fwd), .REV_INHIBIT(rev), .ALARM_SHOWN(alarm_s), .AUTOTUNE_SHOWN(tune_s),
    .UTIL_RESULT_EVT(u_evt), .NO_MOTOR_TEST(nmt), .RUN_ENABLE_A(run_a), .RUN_ENABLE_B(run_b),
    .MOTOR_POWER(mpow), .BRAKE_RELEASE_OUT(brake), .DYN_BRAKE(dyn), .UTILITY_LOCKED(u_lock),
    .DISP_CODE(disp), .NO_MOTOR_MARK(nm_mark));
  hbbs_host hbbs_host_inst (.CLK(CLK), .RSTN(RSTN), .LINK(link), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .IRQ(irq));
  hbbs_monitor hbbs_monitor_inst (.CLK(CLK), .RSTN(RSTN), .cmd_valid(link.cmd_valid),
    .cmd_code(link.cmd_code), .io_monitor(link.io_monitor), .drive_on_flag(link.drive_on_flag),
    .cmd_warning(link.cmd_warning), .input_timing_alarm(link.input_timing_alarm));
  initial begin
    CLK = 1'b0;
    forever #2.5 CLK = ~CLK;
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [31:0] st(input logic al, input logic wn, input logic on,
    input logic bl);
    return {28'h0, al, wn, on, bl};
  endfunction
  function automatic hbbs_disp_type dexp(input logic [2:0] pfr);
    case (pfr)
      3'b100: return DSP_POLARITY;
      3'b011: return DSP_BOTH_INH;
      3'b010: return DSP_FWD_INH;
      3'b001: return DSP_REV_INH;
      default: return DSP_RUN;
    endcase
  endfunction
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge CLK);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge CLK);
    penable <= 1'b1;
    // Settled values here are those seen at the next rising edge
    @(negedge CLK);
    while (pready !== 1'b1) begin
      @(negedge CLK);
    end
    r = prdata;
    e = pslverr;
    @(posedge CLK);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(r, exp);
  endtask
  task automatic cmd(input logic [7:0] c);
    apb(1'b1, APB_CTRL, {24'h0, c});
    repeat (4) @(posedge CLK);
  endtask
  task automatic safe(input logic a, input logic b, input int n);
    @(posedge CLK);
    sa <= a;
    sb <= b;
    repeat (n) @(posedge CLK);
  endtask
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      stop_test();
    end
  end
  initial begin
    {stop_m, u_mode, u_latch, u_cancel, pol, fwd, rev, alarm_s, tune_s, u_evt, nmt} = '0;
    {psel, penable, pwrite, paddr, pwdata, RSTN} = '0;
    sa = 1'b1;
    sb = 1'b1;
    repeat (2) @(posedge CLK);
    RSTN <= 1'b1;
    rd(APB_STAT, st(0, 0, 0, 1));
    check(32'(disp), 32'(DSP_HBB));
    rd(32'h10, 32'h0);
    check(32'(e), 32'h1);
    cmd(CMD_SERVO_ON_CMD);
    rd(APB_STAT, st(0, 0, 1, 0));
    check(32'({mpow, run_a, run_b}), 32'h7);
    $display("reset and start done");
    for (int c = 0; c < 2; c++) begin
      cmd(CMD_STATUS_MON);
      t = xs();
      stop_m <= t[0];
      // Off pulse of at most the glitch window; first pass is the exact limit
      safe(c != 0, c == 0, (c == 0) ? 3 : 32'(t[9:8]));
      safe(1'b1, 1'b1, 11);
      check(32'(mpow), 32'h1);
      safe(c != 0, c == 0, 11);
      check(32'({mpow, brake, dyn, c ? run_b : run_a}), 32'({2'b00, stop_m, 1'b0}));
      check(32'(disp), 32'(DSP_HBB));
      rd(APB_IRQ, 32'h1);
      apb(1'b1, APB_MASK, 32'h0);
      repeat (2) @(negedge CLK);
      i0 = irq;
      apb(1'b1, APB_MASK, 32'h7);
      repeat (2) @(negedge CLK);
      check(32'(i0 ^ irq), 32'h1);
      apb(1'b1, APB_IRQ, 32'h7);
      rd(APB_IRQ, 32'h0);
      safe(1'b1, 1'b1, 11);
      rd(APB_STAT, st(0, 0, 0, 1));
      cmd(CMD_SERVO_ON_CMD);
      rd(APB_STAT, st(0, 0, 1, 0));
    end
    $display("channel gating done");
    cmd(CMD_STATUS_MON);
    safe(1'b0, 1'b0, 11);
    check(32'(mpow), 32'h0);
    cmd(CMD_SERVO_ON_CMD);
    safe(1'b1, 1'b1, 11);
    cmd(CMD_SERVO_ON_CMD);
    rd(APB_STAT, st(0, 0, 0, 1));
    cmd(CMD_SERVO_OFF_CMD);
    cmd(CMD_SERVO_ON_CMD);
    rd(APB_STAT, st(0, 0, 1, 0));
    $display("resume sequence done");
    for (int i = 0; i < 8; i++) begin
      cmd(codes[i]);
      safe(1'b0, 1'b0, 11);
      rd(APB_STAT, st(0, i != 0, 0, 1));
      safe(1'b1, 1'b1, 11);
      cmd(CMD_CLR_WARN);
      cmd(CMD_SERVO_ON_CMD);
      rd(APB_STAT, st(0, 0, 1, 0));
    end
    $display("command warning done");
    cmd(CMD_STATUS_MON);
    safe(1'b1, 1'b0, 70);
    rd(APB_STAT, st(1, 0, 0, 1));
    safe(1'b1, 1'b1, 11);
    cmd(CMD_CLR_WARN);
    cmd(CMD_SERVO_ON_CMD);
    rd(APB_STAT, st(0, 0, 1, 0));
    u_mode <= 1'b1;
    u_latch <= 1'b1;
    safe(1'b0, 1'b0, 11);
    check(32'(mpow), 32'h0);
    safe(1'b1, 1'b1, 11);
    check(32'(u_lock), 32'h1);
    u_cancel <= 1'b1;
    @(posedge CLK);
    {u_cancel, u_mode, u_latch} <= 3'b000;
    repeat (3) @(posedge CLK);
    check(32'(u_lock), 32'h0);
    cmd(CMD_SERVO_ON_CMD);
    $display("alarm and utility done");
    for (int j = 0; j < 5; j++) begin
      t = (j == 0) ? 32'h0 : 32'h1 << (j - 1);
      {pol, fwd, rev} <= (j == 4) ? 3'b011 : t[2:0];
      repeat (4) @(posedge CLK);
      check(32'(disp), 32'(dexp({pol, fwd, rev})));
    end
    {pol, fwd, rev} <= 3'b000;
    cmd(CMD_SERVO_OFF_CMD);
    check(32'(disp), 32'(DSP_POWER_OFF));
    nmt <= 1'b1;
    alarm_s <= 1'b1;
    repeat (3) @(posedge CLK);
    check(32'(nm_mark), 32'h0);
    {alarm_s, tune_s} <= 2'b01;
    repeat (3) @(posedge CLK);
    check(32'(nm_mark), 32'h0);
    {tune_s, u_evt} <= 2'b01;
    @(posedge CLK);
    u_evt <= 1'b0;
    repeat (5) @(posedge CLK);
    check(32'(nm_mark), 32'h0);
    repeat (25) @(posedge CLK);
    check(32'(nm_mark), 32'h1);
    $display("display done");
    stop_test();
  end
endmodule // testbench
